// [bench/dram_refresh_sdram_port_tb.sv]
/*
 Self-checking bench for the refresh port.
 Assumes the model and checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "drsdp_params.svh"
module dram_refresh_sdram_port_tb import drsdp_pkg::*;;
	logic             sys_clk = 1'h0, resetn = 1'h0, clr = 1'h0;
	logic [7:0]       awaddr = 8'h00, araddr = 8'h00;
	logic [31:0]      wdata = 32'h0, rdata, rdv;
	logic             awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic             arvalid = 1'h0, rready = 1'h0, busBusy = 1'h0;
	logic             accessReq = 1'h0, accessArea3 = 1'h0, accessWrite = 1'h0;
	logic             strobeOe, cs2N, cs3N;
	logic [7:0]       accessBytes = 8'hFF, dqmN;
	logic [17:0]      addrOut;
	logic [25:0]      accessAddr = 26'h0;
	logic [1:0]       bresp, rresp, resp;
	logic             awready, wready, bvalid, arready, rvalid, refreshAck;
	logic             overflowIrq, sdramArea2, sdramArea3;
	logic [5:0]       burstBytes;
	drsdp_power_type  powerIn = 5'h00;
	drsdp_strobe_type strobe;
	int               refreshes, rasLow, num_errors = 0, n_checks = 0;
	always #10 sys_clk = ~sys_clk;
	drsdp_refresh_port drsdp_refresh_port_inst (.sys_clk(sys_clk), .resetn(resetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.powerIn(powerIn), .busBusy(busBusy), .accessReq(accessReq),
		.accessWrite(accessWrite), .accessAddr(accessAddr), .accessBytes(accessBytes),
		.accessArea3(accessArea3), .strobe(strobe), .strobeOe(strobeOe),
		.refreshAck(refreshAck), .overflowIrq(overflowIrq), .dqmN(dqmN),
		.addrOut(addrOut), .cs2N(cs2N), .cs3N(cs3N),
		.sdramArea2(sdramArea2), .sdramArea3(sdramArea3), .burstBytes(burstBytes));
	drsdp_dram_model drsdp_dram_model_inst (.sys_clk(sys_clk), .clr(clr),
		.strobe(strobe), .refreshes(refreshes), .rasLow(rasLow));
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'h1;
		w = 1'h1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (aw || w) begin
			@(posedge sys_clk);
			if (aw && awready) begin
				aw = 1'h0;
				awvalid <= 1'h0;
			end
			if (w && wready) begin
				w = 1'h0;
				wvalid <= 1'h0;
			end
		end
		do @(posedge sys_clk); while (!bvalid);
		resp = bresp;
		bready <= 1'h0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge sys_clk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge sys_clk); while (!rvalid);
		rdv = rdata;
		resp = rresp;
		rready <= 1'h0;
		@(posedge sys_clk);
	endtask
	task automatic clear_model;
		clr <= 1'h1;
		@(posedge sys_clk);
		clr <= 1'h0;
	endtask
	task automatic wait_ref(input int n);
		for (int i = 0; i < n && refreshes == 0; i++) @(posedge sys_clk);
	endtask
	task automatic t_regs;
		rd(`DRSDP_OFF_MCR);
		chk(rdv, `DRSDP_RESET_MCR);
		rd(8'h40);
		chk({rdv[1:0], resp}, 4'h2);
		wr(8'h40, 32'h1);
		chk(resp, 2'h2);
	endtask
	task automatic t_off;
		wr(`DRSDP_OFF_REFRESH_COMPARE_VALUE, 32'h1);
		wr(`DRSDP_OFF_REFRESH_TIMER_COUNT, 32'h0);
		wr(`DRSDP_OFF_REFRESH_TIMER_CTRL_STATUS, 32'h1);
		clear_model;
		repeat (100) @(posedge sys_clk);
		chk(refreshes, 0);
	endtask
	task automatic t_cbr;
		powerIn.sleep <= 1'h1;
		wr(`DRSDP_OFF_REFRESH_TIMER_CTRL_STATUS, 32'h0);
		wr(`DRSDP_OFF_MCR, 32'h212);
		wr(`DRSDP_OFF_REFRESH_TIMER_COUNT, 32'h0);
		clear_model;
		wr(`DRSDP_OFF_REFRESH_TIMER_CTRL_STATUS, 32'h1);
		wait_ref(200);
		chk(refreshes, 1);
		repeat (100) @(posedge sys_clk);
		chk(rasLow, 2);
		chk(refreshes >= 8, 1'h1);
		powerIn.sleep <= 1'h0;
	endtask
	task automatic t_busy;
		busBusy <= 1'h1;
		repeat (20) @(posedge sys_clk);
		clear_model;
		repeat (200) @(posedge sys_clk);
		chk({refreshes != 0, refreshAck}, 2'h1);
		busBusy <= 1'h0;
		wait_ref(10);
		chk(refreshes, 1);
	endtask
	task automatic t_ovf;
		busBusy <= 1'h1;
		repeat (20) @(posedge sys_clk);
		wr(`DRSDP_OFF_REFRESH_TIMER_CTRL_STATUS, 32'h11);
		wr(`DRSDP_OFF_REFRESH_COUNT_REG, 32'h0);
		clear_model;
		busBusy <= 1'h0;
		while (!overflowIrq) @(posedge sys_clk);
		chk(refreshes, `DRSDP_LIMIT_HI);
		rd(`DRSDP_OFF_REFRESH_TIMER_CTRL_STATUS);
		chk(rdv[5], 1'h1);
		wr(`DRSDP_OFF_REFRESH_TIMER_CTRL_STATUS, 32'h11);
		repeat (3) @(posedge sys_clk);
		chk(overflowIrq, 1'h0);
		rd(`DRSDP_OFF_REFRESH_TIMER_CTRL_STATUS);
		chk(rdv[5], 1'h0);
	endtask
	task automatic t_self;
		wr(`DRSDP_OFF_REFRESH_COMPARE_VALUE, 32'h3FF);
		wr(`DRSDP_OFF_REFRESH_TIMER_CTRL_STATUS, 32'h41);
		repeat (10) @(posedge sys_clk);
		chk(strobe.cke, 1'h0);
		clear_model;
		wr(`DRSDP_OFF_REFRESH_TIMER_CTRL_STATUS, 32'h1);
		wait_ref(15);
		chk({refreshes[7:0], strobe.cke}, 9'h3);
	endtask
	task automatic t_clk;
		powerIn.clockChange <= 1'h1;
		repeat (5) @(posedge sys_clk);
		chk(strobe.cke, 1'h0);
		powerIn.clockChange <= 1'h0;
		repeat (5) @(posedge sys_clk);
		chk(strobe.cke, 1'h1);
	endtask
	task automatic t_area;
		accessReq <= 1'h1;
		accessArea3 <= 1'h1;
		for (int t = 2; t < 4; t++) begin
			wr(`DRSDP_OFF_BUS_CONTROL_ONE, 32'(t));
			repeat (3) @(posedge sys_clk);
			chk({sdramArea2, sdramArea3}, {t == 3, 1'h1});
			chk(burstBytes, 6'h20);
		end
	endtask
	task automatic t_pins;
		wr(`DRSDP_OFF_MCR, 32'h0);
		wr(`DRSDP_OFF_BUS_CONTROL_ONE, 32'h3);
		powerIn.busReleased <= 1'h1;
		accessArea3 <= 1'h0;
		accessBytes <= 8'h01;
		accessAddr <= 26'h800;
		repeat (5) @(posedge sys_clk);
		chk(strobeOe, 1'h0);
		chk({cs2N, cs3N}, 2'h1);
		chk(dqmN, 8'h7F);
		chk(addrOut, 18'h8);
		wr(`DRSDP_OFF_BUS_CONTROL_ONE, 32'h1B);
		wr(`DRSDP_OFF_MCR, 32'h1000);
		accessArea3 <= 1'h1;
		accessWrite <= 1'h1;
		repeat (5) @(posedge sys_clk);
		chk(strobeOe, 1'h1);
		chk({cs2N, cs3N}, 2'h2);
		chk(dqmN, 8'hFE);
		chk(addrOut, 18'h4);
		chk(strobe.rdWrN, 1'h0);
		powerIn.busReleased <= 1'h0;
		accessWrite <= 1'h0;
		accessReq <= 1'h0;
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		resetn <= 1'h1;
		@(posedge sys_clk);
		t_regs;
		t_off;
		t_cbr;
		t_busy;
		t_ovf;
		t_self;
		t_clk;
		t_area;
		t_pins;
		complete_run;
	end
	initial begin
		repeat (60000) @(posedge sys_clk);
		num_errors++;
		complete_run;
	end
endmodule
`default_nettype wire

// [bench/drsdp_dram_model.sv]
/*
 DRAM chip model: counts refresh cycles and RAS low length.
 Assumes registered strobes on sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module drsdp_dram_model import drsdp_pkg::*; (
	// Clock and bench control
	input  wire logic             sys_clk,
	input  wire logic             clr,
	// Strobes from the port
	input  wire drsdp_strobe_type strobe,
	// Observations
	output int                    refreshes,
	output int                    rasLow
);
	int   run = 0;
	logic rasPrev = 1'h1;
	always @(posedge sys_clk) begin
		// CAS low as RAS falls, clock enabled: one refresh
		if (clr) begin
			refreshes <= 0;
		end else if (rasPrev && !strobe.rasN && !strobe.casN && strobe.cke) begin
			refreshes <= refreshes + 1;
		end
		if (!strobe.rasN) begin
			run <= run + 1;
		end else if (!rasPrev) begin
			rasLow <= run;
			run <= 0;
		end
		rasPrev <= strobe.rasN;
	end
endmodule
`default_nettype wire

// [bench/drsdp_refresh_port_asserts.sv]
/*
 Protocol and refresh checks for the port.
 Assumes binding to drsdp_refresh_port.
*/
`timescale 1ns/10ps
`default_nettype none
module drsdp_refresh_port_asserts import drsdp_pkg::*; (
	// Clock and reset
	input wire logic             sys_clk, resetn,
	// Register bus
	input wire logic             awvalid, awready, wvalid, wready, bvalid, bready,
	input wire logic             arvalid, arready, rvalid,
	// Refresh side
	input wire drsdp_power_type  powerIn,
	input wire logic             busBusy, refreshAck, overflowIrq,
	input wire drsdp_strobe_type strobe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	AST_REF_ACK: assert property (
		!strobe.rasN && !strobe.casN && strobe.rdWrN && strobe.cke |-> refreshAck)
		else $error("refresh without acknowledge");
	AST_BUSY_HOLD: assert property (
		busBusy [*5] |-> !($fell(strobe.rasN) && !strobe.casN && strobe.cke))
		else $error("refresh started on busy bus");
	AST_RAS_PRECH: assert property (
		$rose(strobe.rasN) && !$past(strobe.casN) |=> strobe.rasN)
		else $error("no precharge after refresh");
	AST_CKE_CHANGE: assert property (
		powerIn.clockChange [*4] |-> !strobe.cke)
		else $error("clock enable high in clock change");
	AST_W_ANSWER: assert property (awvalid && awready && wvalid && wready |=> bvalid)
		else $error("write not answered");
	AST_B_ONCE: assert property (bvalid && bready |=> !bvalid)
		else $error("write answered twice");
	AST_R_ANSWER: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered");
	AST_AR_REFUSE: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	cover property ($fell(strobe.rasN) && !strobe.casN && strobe.cke);
	cover property ($rose(overflowIrq));
	cover property (bvalid && bready);
endmodule
bind drsdp_refresh_port drsdp_refresh_port_asserts drsdp_refresh_port_asserts_inst (
	.sys_clk(sys_clk), .resetn(resetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .rvalid(rvalid), .powerIn(powerIn),
	.busBusy(busBusy), .refreshAck(refreshAck), .overflowIrq(overflowIrq),
	.strobe(strobe));
`default_nettype wire

// [rtl/drsdp_params.svh]
/*
 Register offsets, field positions, the memory control reset value and refresh count limits of the
 refresh and synchronous DRAM port. Assumes an AXI4-Lite slave decoding
 word addresses with these byte offsets.
*/
`ifndef DRSDP_PARAMS_SVH
`define DRSDP_PARAMS_SVH
`define DRSDP_OFF_MCR     8'h00
`define DRSDP_OFF_REFRESH_TIMER_CTRL_STATUS   8'h04
`define DRSDP_OFF_REFRESH_TIMER_COUNT   8'h08
`define DRSDP_OFF_REFRESH_COMPARE_VALUE   8'h0C
`define DRSDP_OFF_REFRESH_COUNT_REG    8'h10
`define DRSDP_OFF_BUS_CONTROL_ONE    8'h14
`define DRSDP_OFF_STATUS  8'h18
// Memory control fields
`define DRSDP_MCR_MODE    0
`define DRSDP_MCR_RFEN    1
`define DRSDP_MCR_TRAS    4
`define DRSDP_MCR_TRC     8
`define DRSDP_MCR_AMX     12
`define DRSDP_MCR_ADDRESS_MUX_EXTEND  15
`define DRSDP_MCR_SZ      16
`define DRSDP_MCR_BURST   18
`define DRSDP_MCR_HOLD    19
// Timer control/status fields
`define DRSDP_CS_CKS      0
`define DRSDP_CS_COUNT_LIMIT_SELECT     3
`define DRSDP_CS_OVERFLOW_IRQ_ENABLE     4
`define DRSDP_CS_OVF      5
`define DRSDP_CS_SELF     6
// Bus control fields
`define DRSDP_BC_TYPE     0
`define DRSDP_BC_HIZ      3
`define DRSDP_BC_LITTLE   4
`define DRSDP_TYPE_A3     3'h2
`define DRSDP_TYPE_A23    3'h3
`define DRSDP_LIMIT_LO    10'h3FF
`define DRSDP_LIMIT_HI    10'h1FF
`define DRSDP_RESET_MCR   32'h00000000
`endif

// [rtl/drsdp_pkg.sv]
/*
 Types of the refresh and synchronous DRAM port.
 Assumes drsdp_params.svh is included alongside.
*/
`default_nettype none
package drsdp_pkg;
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_RAS    = 4'b0010,
		ST_PRECH  = 4'b0100,
		ST_SELF   = 4'b1000
	} drsdp_state_type;
	typedef struct packed {
		logic rasN;
		logic casN;
		logic rdWrN;
		logic cke;
	} drsdp_strobe_type;
	typedef struct packed {
		logic        sleep;
		logic        standby;
		logic        manualReset;
		logic        busReleased;
		logic        clockChange;
	} drsdp_power_type;
endpackage
`default_nettype wire

// [rtl/drsdp_refresh_port.sv]
/*
 Refresh timer, refresh counter with overflow event, refresh cycle sequencer,
 self-refresh, CKE, byte masks, command encoding and address multiplexing.
 Assumes an AXI4-Lite master on sys_clk and asynchronous bus pins.
*/
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "drsdp_params.svh"
module drsdp_refresh_port
	import drsdp_pkg::*;
(
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	// AXI4-Lite slave
	input  wire logic [7:0]        awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [7:0]        araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// System state and external bus
	input  wire drsdp_power_type   powerIn,
	input  wire logic              busBusy,
	input  wire logic              accessReq,
	input  wire logic              accessWrite,
	input  wire logic [25:0]       accessAddr,
	input  wire logic [7:0]        accessBytes,
	input  wire logic              accessArea3,
	// DRAM pins
	output drsdp_strobe_type       strobe,
	output logic                   strobeOe,
	output logic                   refreshAck,
	output logic                   overflowIrq,
	output logic [7:0]             dqmN,
	output logic [17:0]            addrOut,
	output logic                   cs2N,
	output logic                   cs3N,
	output logic                   sdramArea2,
	output logic                   sdramArea3,
	output logic [5:0]             burstBytes
);
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	// Pin synchronisers
	drsdp_power_type pwrMeta, pwr;
	logic [1:0]      busMeta, busSync;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pwrMeta <= '0;
			pwr     <= '0;
			busMeta <= 2'h0;
			busSync <= 2'h0;
		end else begin
			pwrMeta <= powerIn;
			pwr     <= pwrMeta;
			busMeta <= {busBusy, accessReq};
			busSync <= busMeta;
		end
	end
	wire logic busHeld = busSync[1];
	wire logic accReq  = busSync[0];

	// Registers
	logic [31:0] memory_control_reg, next_mcr;
	logic [6:0]  csr, next_csr;
	logic [9:0]  cnt, next_cnt, cor, next_cor, rfc, next_rfc;
	logic [4:0]  bcr, next_bcr;
	logic [11:0] pre, next_pre;
	logic        pending, next_pending;
	logic        rowOpen, next_rowOpen;
	logic [2:0]  stepCnt, next_stepCnt;
	drsdp_state_type state, next_state;
	logic        awSeen, next_awSeen, wSeen, next_wSeen, bv, next_bv;
	logic [7:0]  awLat, next_awLat;
	logic [31:0] wLat, next_wLat, rd, next_rd;
	logic [1:0]  br, next_br, rr, next_rr;
	logic        rv, next_rv;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = be[i] ? val[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	// Prescaler tap per clock select; 0 stops the timer
	function automatic logic tick(input logic [2:0] sel, input logic [11:0] p);
		case (sel)
			3'h0: tick = 1'b0;
			3'h1: tick = p[1:0] == 2'h3;
			3'h2: tick = p[3:0] == 4'hF;
			3'h3: tick = p[5:0] == 6'h3F;
			3'h4: tick = p[7:0] == 8'hFF;
			3'h5: tick = p[9:0] == 10'h3FF;
			default: tick = p == 12'hFFF;
		endcase
	endfunction

	wire logic [2:0] cks     = csr[`DRSDP_CS_CKS +: 3];
	wire logic       selfReq = csr[`DRSDP_CS_SELF];
	wire logic       cbrOn   = !memory_control_reg[`DRSDP_MCR_MODE] && memory_control_reg[`DRSDP_MCR_RFEN];
	wire logic [9:0] limit   = csr[`DRSDP_CS_COUNT_LIMIT_SELECT] ? `DRSDP_LIMIT_LO : `DRSDP_LIMIT_HI;
	wire logic       match   = cnt == cor;
	wire logic       startRef = state == ST_IDLE && pending && !busHeld && cbrOn;
	wire logic       ovfEvent = state == ST_RAS && stepCnt == 3'h0 && rfc + 10'h1 == limit;

	wire logic wrGo = (awSeen || awvalid) && (wSeen || wvalid) && !bv;
	wire logic [7:0]  wA = awSeen ? awLat : awaddr;
	wire logic [31:0] wD = wSeen ? wLat : wdata;
	wire logic        wrOk = wA == `DRSDP_OFF_MCR || wA == `DRSDP_OFF_REFRESH_TIMER_CTRL_STATUS ||
		wA == `DRSDP_OFF_REFRESH_TIMER_COUNT || wA == `DRSDP_OFF_REFRESH_COMPARE_VALUE || wA == `DRSDP_OFF_REFRESH_COUNT_REG ||
		wA == `DRSDP_OFF_BUS_CONTROL_ONE;

	always_comb begin
		next_mcr = memory_control_reg; next_csr = csr; next_cnt = cnt; next_cor = cor;
		next_rfc = rfc; next_bcr = bcr; next_pending = pending;
		next_state = state; next_stepCnt = stepCnt; next_rowOpen = rowOpen;
		next_pre = pre + 12'h1;
		next_awSeen = awSeen; next_wSeen = wSeen; next_awLat = awLat; next_wLat = wLat;
		next_bv = bv; next_br = br; next_rv = rv; next_rr = rr; next_rd = rd;
		// Timer counts from its present value
		if (tick(cks, pre))
			next_cnt = cnt + 10'h1;
		if (match && cks != 3'h0 && cbrOn)
			next_pending = 1'b1;
		case (state)
			ST_IDLE: begin
				if (selfReq && cbrOn)
					next_state = ST_SELF;
				else if (startRef) begin
					next_state   = ST_RAS;
					next_pending = 1'b0;
					next_cnt     = 10'h0;
					next_stepCnt = memory_control_reg[`DRSDP_MCR_TRAS +: 3];
				end
			end
			ST_RAS: begin
				if (stepCnt == 3'h0) begin
					next_state   = ST_PRECH;
					next_stepCnt = memory_control_reg[`DRSDP_MCR_TRC +: 3];
					if (ovfEvent) begin
						next_rfc = 10'h0;
						next_csr[`DRSDP_CS_OVF] = 1'b1;
					end else
						next_rfc = rfc + 10'h1;
				end else
					next_stepCnt = stepCnt - 3'h1;
			end
			ST_PRECH: begin
				if (stepCnt == 3'h0)
					next_state = ST_IDLE;
				else
					next_stepCnt = stepCnt - 3'h1;
			end
			ST_SELF: begin
				if (!selfReq) begin
					next_state   = ST_PRECH;
					next_stepCnt = memory_control_reg[`DRSDP_MCR_TRC +: 3];
					next_pending = 1'b1;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		// Row held open only between accesses; refresh or bus loss closes it
		if (pending || busHeld || state != ST_IDLE)
			next_rowOpen = 1'b0;
		else if (accReq && memory_control_reg[`DRSDP_MCR_HOLD] && accessArea3)
			next_rowOpen = 1'b1;
		// AXI4-Lite write side
		if (awvalid && !awSeen && !wrGo) begin
			next_awSeen = 1'b1; next_awLat = awaddr;
		end
		if (wvalid && !wSeen && !wrGo) begin
			next_wSeen = 1'b1; next_wLat = wdata;
		end
		if (wrGo) begin
			next_awSeen = 1'b0; next_wSeen = 1'b0; next_bv = 1'b1;
			next_br = wrOk ? RESP_OK : RESP_ERR;
			case (wA)
				`DRSDP_OFF_MCR:   next_mcr = merge(memory_control_reg, wD, wstrb);
				`DRSDP_OFF_REFRESH_TIMER_CTRL_STATUS: begin
					next_csr[4:0] = wD[4:0];
					next_csr[`DRSDP_CS_SELF] = wD[`DRSDP_CS_SELF];
					// Overflow flag clears on write of 0; a new event wins
					if (!wD[`DRSDP_CS_OVF] && !ovfEvent)
						next_csr[`DRSDP_CS_OVF] = 1'b0;
				end
				`DRSDP_OFF_REFRESH_TIMER_COUNT: next_cnt = wD[9:0];
				`DRSDP_OFF_REFRESH_COMPARE_VALUE: next_cor = wD[9:0];
				`DRSDP_OFF_REFRESH_COUNT_REG:  next_rfc = wD[9:0];
				`DRSDP_OFF_BUS_CONTROL_ONE:  next_bcr = wD[4:0];
				default: ;
			endcase
		end
		if (bv && bready)
			next_bv = 1'b0;
		// AXI4-Lite read side
		if (arvalid && !rv) begin
			next_rv = 1'b1;
			next_rr = RESP_OK;
			case (araddr)
				`DRSDP_OFF_MCR:    next_rd = memory_control_reg;
				`DRSDP_OFF_REFRESH_TIMER_CTRL_STATUS:  next_rd = {25'h0, csr};
				`DRSDP_OFF_REFRESH_TIMER_COUNT:  next_rd = {22'h0, cnt};
				`DRSDP_OFF_REFRESH_COMPARE_VALUE:  next_rd = {22'h0, cor};
				`DRSDP_OFF_REFRESH_COUNT_REG:   next_rd = {22'h0, rfc};
				`DRSDP_OFF_BUS_CONTROL_ONE:   next_rd = {27'h0, bcr};
				`DRSDP_OFF_STATUS: next_rd = {26'h0, rowOpen, pending, state};
				default: begin
					next_rd = 32'h0; next_rr = RESP_ERR;
				end
			endcase
		end else if (rv && rready)
			next_rv = 1'b0;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			memory_control_reg <= `DRSDP_RESET_MCR; csr <= 7'h0; cnt <= 10'h0; cor <= 10'h0;
			rfc <= 10'h0; bcr <= 5'h0; pre <= 12'h0; pending <= 1'b0;
			state <= ST_IDLE; stepCnt <= 3'h0; rowOpen <= 1'b0;
			awSeen <= 1'b0; wSeen <= 1'b0; awLat <= 8'h0; wLat <= 32'h0;
			bv <= 1'b0; br <= 2'h0; rv <= 1'b0; rr <= 2'h0; rd <= 32'h0;
		end else begin
			memory_control_reg <= next_mcr; csr <= next_csr; cnt <= next_cnt; cor <= next_cor;
			rfc <= next_rfc; bcr <= next_bcr; pre <= next_pre; pending <= next_pending;
			state <= next_state; stepCnt <= next_stepCnt; rowOpen <= next_rowOpen;
			awSeen <= next_awSeen; wSeen <= next_wSeen; awLat <= next_awLat;
			wLat <= next_wLat; bv <= next_bv; br <= next_br; rv <= next_rv;
			rr <= next_rr; rd <= next_rd;
		end
	end

	assign awready = !awSeen && !bv;
	assign wready  = !wSeen && !bv;
	assign bvalid  = bv;
	assign bresp   = br;
	assign arready = !rv;
	assign rvalid  = rv;
	assign rresp   = rr;
	assign rdata   = rd;

	// Pin side, registered
	logic [2:0] memType;
	logic [7:0] maskLane;
	logic [17:0] rowAddr;
	logic [3:0]  colBits;
	logic        isSdram;
	always_comb begin
		memType = bcr[`DRSDP_BC_TYPE +: 3];
		isSdram = memType == `DRSDP_TYPE_A3 || memType == `DRSDP_TYPE_A23;
		// Masks active low; lane order follows endian mode
		for (int i = 0; i < 8; i++)
			maskLane[i] = bcr[`DRSDP_BC_LITTLE] ? !accessBytes[i] : !accessBytes[7 - i];
		// Row address: pin n shows address bit n plus column width, top pins keep own bit
		colBits = (memory_control_reg[`DRSDP_MCR_ADDRESS_MUX_EXTEND] || memory_control_reg[`DRSDP_MCR_AMX +: 3] > 3'h4) ? 4'hC :
			4'h8 + {1'b0, memory_control_reg[`DRSDP_MCR_AMX +: 3]};
		rowAddr[0] = 1'b0;
		for (int i = 1; i < 18; i++)
			rowAddr[i] = (i + colBits < 26) ? accessAddr[i + colBits] : accessAddr[i];
	end
	wire logic refRas = state == ST_RAS;
	wire logic selfOn = state == ST_SELF;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			strobe <= '{rasN: 1'b1, casN: 1'b1, rdWrN: 1'b1, cke: 1'b0};
			strobeOe <= 1'b0; refreshAck <= 1'b0; overflowIrq <= 1'b0;
			dqmN <= 8'hFF; addrOut <= 18'h0; cs2N <= 1'b1; cs3N <= 1'b1;
			sdramArea2 <= 1'b0; sdramArea3 <= 1'b0; burstBytes <= 6'h0;
		end else begin
			// REF/SELF: RAS and CAS low, read/write high; others via access path
			strobe.rasN  <= !(refRas || selfOn || rowOpen);
			strobe.casN  <= !(refRas || selfOn);
			strobe.rdWrN <= !(accReq && accessWrite && !refRas && !selfOn);
			strobe.cke   <= !(selfOn || pwr.clockChange);
			strobeOe     <= !((pwr.busReleased || pwr.standby) && !bcr[`DRSDP_BC_HIZ]);
			refreshAck   <= pending || refRas;
			overflowIrq  <= csr[`DRSDP_CS_OVF] && csr[`DRSDP_CS_OVERFLOW_IRQ_ENABLE];
			dqmN         <= maskLane;
			addrOut      <= rowOpen ? {accessAddr[17:2], 2'h0} : {rowAddr[17:2], 2'h0};
			// Shared strobes qualified by chip selects
			cs2N <= !(accReq && !accessArea3 && memType == `DRSDP_TYPE_A23);
			cs3N <= !((accReq && accessArea3) || refRas || selfOn);
			sdramArea2 <= memType == `DRSDP_TYPE_A23;
			sdramArea3 <= isSdram;
			burstBytes <= isSdram ? 6'h20 : (memory_control_reg[`DRSDP_MCR_BURST] ? 6'h20 : 6'h4);
		end
	end
endmodule
`default_nettype wire
